// file: rtl/cssc_defines.vh
`ifndef CSSC_DEFINES_VH
`define CSSC_DEFINES_VH

// register port offsets
`define CSSC_ADDR_TRIM        4'h0
`define CSSC_ADDR_STATUS      4'h1
`define CSSC_ADDR_FUSES       4'h2
`define CSSC_ADDR_PRESCALE    4'h3

// source classes decoded from the select fuses
`define CSSC_SRC_EXT          3'h0
`define CSSC_SRC_RC4          3'h1
`define CSSC_SRC_RC8          3'h2
`define CSSC_SRC_WDOSC        3'h3
`define CSSC_SRC_XTAL         3'h4

// factory fuse image (zero means programmed)
`define CSSC_FUSE_SRC_DEFAULT 4'h2
`define CSSC_FUSE_SUT_DEFAULT 2'h2
`define CSSC_FUSE_DIV_DEFAULT 1'h0

// prescaler reset values
`define CSSC_PRESC_DIV8       4'h3
`define CSSC_PRESC_DIV1       4'h0

// wake-up counts in source clock cycles
`define CSSC_WAKE_SHORT       16'h0006
`define CSSC_WAKE_258         16'h0102
`define CSSC_WAKE_1K          16'h0400
`define CSSC_WAKE_16K         16'h4000
`define CSSC_RESET_CK         16'h000E

// watchdog oscillator time-out lengths in oscillator cycles
`define CSSC_WD_4K            17'h0_1000
`define CSSC_WD_64K           17'h1_0000

// reset delay selector
`define CSSC_RD_NONE          2'h0
`define CSSC_RD_4K            2'h1
`define CSSC_RD_64K           2'h2

// trim register
`define CSSC_TRIM_WIDTH       7
`define CSSC_TRIM_MAX         7'h7F
`define CSSC_TRIM_DEFAULT     8'h40

`endif

// file: rtl/cssc_sync.v
`timescale 1ns/1ps
`default_nettype none

// two flop synchroniser for one level
module cssc_sync (
  // clock and reset
  input  wire clk,
  input  wire rst,
  // level in and out
  input  wire d,
  output wire q
);

  reg s1_reg; // first stage, read only by s2
  reg s2_reg; // second stage

  // shift through two stages
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
    end else begin
      s1_reg <= d;
      s2_reg <= s1_reg;
    end
  end

  assign q = s2_reg;

endmodule // cssc_sync

`default_nettype wire

// file: rtl/cssc_decode.v
`timescale 1ns/1ps
`default_nettype none
`include "cssc_defines.vh"

// fuse field decoder: source class, crystal mode and delays
module cssc_decode (
  // fuse image, one means unprogrammed
  input  wire [3:0]  source_select_fuses,
  input  wire [1:0]  startup_select_fuses,
  // decoded results
  output reg  [2:0]  src_class,
  output wire [2:0]  xtal_mode,
  output reg  [15:0] wake_count,
  output reg  [1:0]  reset_delay,
  output reg         sut_reserved
);

  wire source_select_low_bit; // lowest select bit
  assign source_select_low_bit = source_select_fuses[0];
  assign xtal_mode = source_select_fuses[3:1];

  // class from the upper select bits
  always @* begin
    case (source_select_fuses[3:1])
      3'h0:    src_class = `CSSC_SRC_EXT;
      3'h1:    src_class = `CSSC_SRC_RC4;
      3'h2:    src_class = `CSSC_SRC_RC8;
      3'h3:    src_class = `CSSC_SRC_WDOSC;
      default: src_class = `CSSC_SRC_XTAL;
    endcase
  end

  // start-up figures per class and start-up code
  always @* begin
    wake_count   = `CSSC_WAKE_SHORT;
    reset_delay  = `CSSC_RD_NONE;
    sut_reserved = 1'b0;
    if (source_select_fuses[3]) begin
      // crystal table, eight rows by low bit and code
      case ({source_select_low_bit, startup_select_fuses})
        3'h0, 3'h1:       wake_count = `CSSC_WAKE_258;
        3'h2, 3'h3, 3'h4: wake_count = `CSSC_WAKE_1K;
        default:          wake_count = `CSSC_WAKE_16K;
      endcase
      case ({source_select_low_bit, startup_select_fuses})
        3'h0, 3'h3, 3'h6: reset_delay = `CSSC_RD_4K;
        3'h1, 3'h4, 3'h7: reset_delay = `CSSC_RD_64K;
        default:          reset_delay = `CSSC_RD_NONE;
      endcase
    end else begin
      // rc, watchdog osc and external share one table
      case (startup_select_fuses)
        2'h0:    reset_delay = `CSSC_RD_NONE;
        2'h1:    reset_delay = `CSSC_RD_4K;
        2'h2:    reset_delay = `CSSC_RD_64K;
        default: begin
          reset_delay  = `CSSC_RD_64K;
          sut_reserved = 1'b1;
        end
      endcase
    end
  end

endmodule // cssc_decode

`default_nettype wire

// file: rtl/cssc_top.v
// The address map and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "cssc_defines.vh"

// start-up flow in brief:
//   reset holds the sequencer idle and shows the factory fuse image
//   first edge after release captures fuses, trim and prescaler
//   sequencer then counts fourteen source cycles
//   a non-zero reset delay adds whole watchdog oscillator periods
//   only then does core_run rise, in one step
//   power-down followed by a wake level restarts the source count
//   a wake restart never adds the watchdog delay
//
// counting detail:
//   COUNT is entered with the counter at zero and leaves when it
//   reaches the figure minus one, so the figure is met exactly
//   WDOG counts synchronised watchdog edges the same way
//   wake figures: 6 cycles for rc, watchdog osc and external,
//   258, 1K or 16K for the crystal table
//
// register map on the plain port:
//   trim      full byte, bits 6..0 reach the oscillator
//   status    read-only view of the sequencer
//   fuses     read-only copy of the captured fuse image
//   prescale  run-time divide select, low nibble only
//   all other offsets read zero and ignore writes
//
// hazards and limits:
//   fuses are treated as static; they are caught once, unsynchronised
//   the watchdog oscillator is slow and asynchronous, so only its
//   synchronised rising edges are counted, never its raw level
//   each watchdog oscillator level must last at least one clk period
//   a reserved start-up code on a non-crystal source falls back
//   to the longest delay and is flagged in the status byte
//   writes in the first cycle after reset are dropped, since the
//   capture step owns the trim and prescaler then
//   read data stand for one cycle only and read zero otherwise

module cssc_top (
  // clock and reset
  input  wire        clk,
  input  wire        rst,
  // non-volatile fuse image and calibration byte
  input  wire [3:0]  source_select_fuses,
  input  wire [1:0]  startup_select_fuses,
  input  wire        divide_by_eight_fuse,
  input  wire [7:0]  calib_byte,
  // watchdog oscillator clock, sampled as a pin
  input  wire        wd_osc_pin,
  // power-down wake request and sleep state
  input  wire        wake_req,
  input  wire        power_down,
  // asynchronous wake sources, active while peripheral clock halted
  input  wire        ext_irq_pin,
  input  wire        serial_start_pin,
  // register port
  input  wire [3:0]  reg_addr,
  input  wire [7:0]  reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [7:0]  reg_rdata,
  // clock control outputs
  output wire        core_run,
  output wire        cpu_clk_en,
  output wire        flash_clk_en,
  output wire [2:0]  src_class,
  output wire [2:0]  xtal_mode,
  output wire [6:0]  trim_value,
  output wire [3:0]  prescaler_select,
  output wire        wd_clk_for_watchdog,
  output wire        async_wake
);

  // start-up state machine codes
  // binary codes; the status byte shows them as they are
  localparam ST_IDLE  = 2'h0; // latching fuses after reset
  localparam ST_COUNT = 2'h1; // counting source cycles
  localparam ST_WDOG  = 2'h2; // counting watchdog cycles
  localparam ST_RUN   = 2'h3; // core released

  reg  [1:0]  state_reg;       // start-up state
  reg  [1:0]  state_next;      // next start-up state
  reg  [15:0] ck_cnt_reg;      // source cycle counter
  reg  [15:0] ck_cnt_next;     // next source count
  reg  [16:0] wd_cnt_reg;      // watchdog cycle counter
  reg  [16:0] wd_cnt_next;     // next watchdog count
  reg  [16:0] wd_target_reg;   // latched watchdog length
  reg  [16:0] wd_target_next;  // next watchdog length
  reg  [7:0]  trim_reg;        // oscillator_trim register
  reg  [3:0]  presc_reg;       // run-time prescaler select
  reg  [3:0]  src_fuse_reg;    // fuses caught after reset
  reg  [1:0]  sut_fuse_reg;    // start-up fuses caught
  reg         div8_fuse_reg;   // divide fuse caught
  reg         loaded_reg;      // fuse capture done
  reg         from_reset_reg;  // current start-up came from reset
  reg         wd_prev_reg;     // last synchronised watchdog level
  reg         pd_prev_reg;     // last synchronised power-down level

  wire        wd_sync;         // synchronised watchdog osc
  wire        wake_sync;       // synchronised wake request
  wire        pd_sync;         // synchronised power-down
  wire        wd_tick;         // rising edge of watchdog osc
  wire [15:0] wake_count;      // decoded wake count
  wire [1:0]  reset_delay;     // decoded reset delay
  wire        sut_reserved;    // reserved start-up code seen

  // synchronisers for outside levels
  // the wake and power-down levels come from logic that runs while
  // this clock may be stopped, so they are treated as pins
  cssc_sync u_sync_wd (
    .clk (clk),
    .rst (rst),
    .d   (wd_osc_pin),
    .q   (wd_sync)
  );
  cssc_sync u_sync_wake (
    .clk (clk),
    .rst (rst),
    .d   (wake_req),
    .q   (wake_sync)
  );
  cssc_sync u_sync_pd (
    .clk (clk),
    .rst (rst),
    .d   (power_down),
    .q   (pd_sync)
  );

  // fuse decoder fed from the captured image
  // all start-up figures but the fixed 14-cycle reset count follow from the captured fuses alone
  cssc_decode u_decode (
    .source_select_fuses  (src_fuse_reg),
    .startup_select_fuses (sut_fuse_reg),
    .src_class            (src_class),
    .xtal_mode            (xtal_mode),
    .wake_count           (wake_count),
    .reset_delay          (reset_delay),
    .sut_reserved         (sut_reserved)
  );

  // watchdog length from decoded delay
  // zero length means no watchdog phase at all
  function [16:0] wd_len;
    input [1:0] sel;
    begin
      case (sel)
        `CSSC_RD_4K:  wd_len = `CSSC_WD_4K;
        `CSSC_RD_64K: wd_len = `CSSC_WD_64K;
        default:      wd_len = 17'h0_0000;
      endcase
    end
  endfunction

  // one-cycle pulse per watchdog oscillator period
  assign wd_tick = wd_sync & ~wd_prev_reg;

  // edge history of synchronised levels
  // wd_prev starts low, the same as the synchronised idle level,
  // so no false watchdog edge follows reset
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      wd_prev_reg <= 1'b0;
      pd_prev_reg <= 1'b0;
    end else begin
      wd_prev_reg <= wd_sync;
      pd_prev_reg <= pd_sync;
    end
  end

  // fuse image caught once after reset release
  // the factory image stands in during reset so that the decoded
  // outputs show the shipped setting until capture
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      src_fuse_reg  <= `CSSC_FUSE_SRC_DEFAULT;
      sut_fuse_reg  <= `CSSC_FUSE_SUT_DEFAULT;
      div8_fuse_reg <= `CSSC_FUSE_DIV_DEFAULT;
      loaded_reg    <= 1'b0;
    end else if (!loaded_reg) begin
      src_fuse_reg  <= source_select_fuses;
      sut_fuse_reg  <= startup_select_fuses;
      div8_fuse_reg <= divide_by_eight_fuse;
      loaded_reg    <= 1'b1;
    end
  end

  // start-up sequencer next state
  always @* begin
    state_next     = state_reg;
    ck_cnt_next    = ck_cnt_reg;
    wd_cnt_next    = wd_cnt_reg;
    wd_target_next = wd_target_reg;
    case (state_reg)
      ST_IDLE: begin
        // reset start: 14 cycles then watchdog delay
        // the decoder still sees the factory image in this cycle,
        // so the watchdog length is taken later, at the end of COUNT
        state_next     = ST_COUNT;
        ck_cnt_next    = 16'h0000;
        wd_cnt_next    = 17'h0_0000;
        wd_target_next = 17'h0_0000;
      end
      ST_COUNT: begin
        // count source cycles for reset or wake figure
        if ((from_reset_reg && ck_cnt_reg == `CSSC_RESET_CK - 16'h0001) ||
            (!from_reset_reg && ck_cnt_reg == wake_count - 16'h0001)) begin
          if (from_reset_reg && reset_delay != `CSSC_RD_NONE) begin
            // reset start with a watchdog delay: latch its length
            state_next     = ST_WDOG;
            wd_cnt_next    = 17'h0_0000;
            wd_target_next = wd_len(reset_delay);
          end else begin
            // wake start, or reset start with no extra delay
            state_next = ST_RUN;
          end
        end else begin
          // still counting
          ck_cnt_next = ck_cnt_reg + 16'h0001;
        end
      end
      ST_WDOG: begin
        // count watchdog oscillator edges
        if (wd_tick) begin
          if (wd_cnt_reg == wd_target_reg - 17'h0_0001) begin
            state_next = ST_RUN;
          end else begin
            wd_cnt_next = wd_cnt_reg + 17'h0_0001;
          end
        end
      end
      ST_RUN: begin
        // power-down then wake restarts the count
        if (pd_prev_reg && wake_sync) begin
          state_next  = ST_COUNT;
          ck_cnt_next = 16'h0000;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // sequencer registers
  // from_reset stays set from reset until the first wake restart
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg      <= ST_IDLE;
      ck_cnt_reg     <= 16'h0000;
      wd_cnt_reg     <= 17'h0_0000;
      wd_target_reg  <= 17'h0_0000;
      from_reset_reg <= 1'b1;
    end else begin
      state_reg      <= state_next;
      ck_cnt_reg     <= ck_cnt_next;
      wd_cnt_reg     <= wd_cnt_next;
      wd_target_reg  <= wd_target_next;
      if (state_reg == ST_RUN && state_next == ST_COUNT) begin
        from_reset_reg <= 1'b0;
      end
    end
  end

  // trim and prescaler registers
  // the capture cycle loads both, so a write landing then is dropped;
  // after that software owns them until the next reset
  // trim is taken whole; only bits 6..0 reach the oscillator
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      trim_reg  <= `CSSC_TRIM_DEFAULT;
      presc_reg <= `CSSC_PRESC_DIV8;
    end else if (!loaded_reg) begin
      trim_reg  <= calib_byte;
      // programmed (zero) fuse gives divide by eight
      presc_reg <= divide_by_eight_fuse ? `CSSC_PRESC_DIV1 : `CSSC_PRESC_DIV8;
    end else if (reg_wr) begin
      case (reg_addr)
        `CSSC_ADDR_TRIM:     trim_reg  <= reg_wdata;
        `CSSC_ADDR_PRESCALE: presc_reg <= reg_wdata[3:0];
        default:             trim_reg  <= trim_reg;
      endcase
    end
  end

  // read data, one cycle after strobe
  // status byte: bits 7..5 zero, bit 4 reserved start-up code,
  // bit 3 start-up came from reset, bit 2 core released,
  // bits 1..0 sequencer state
  // fuse byte: bit 6 divide fuse, bits 5..4 start-up, bits 3..0 source
  // the bus is returned to zero when no read is pending
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `CSSC_ADDR_TRIM:     reg_rdata <= trim_reg;
        `CSSC_ADDR_STATUS:   reg_rdata <= {3'h0, sut_reserved, from_reset_reg, core_run, state_reg};
        `CSSC_ADDR_FUSES:    reg_rdata <= {1'b0, div8_fuse_reg, sut_fuse_reg, src_fuse_reg};
        `CSSC_ADDR_PRESCALE: reg_rdata <= {4'h0, presc_reg};
        default:             reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // outputs
  // core_run and the clock enables are decoded straight from the
  // state register, so they change on the same edge as the sequencer does
  // the cpu and flash enables drop as soon as power-down is seen
  assign core_run            = (state_reg == ST_RUN);
  assign cpu_clk_en          = core_run & ~pd_sync;
  assign flash_clk_en        = cpu_clk_en;
  assign trim_value          = trim_reg[6:0];
  assign prescaler_select    = presc_reg;
  assign wd_clk_for_watchdog = wd_osc_pin;
  // combinational wake, no clock needed while halted
  assign async_wake          = ext_irq_pin | serial_start_pin;

endmodule // cssc_top

`default_nettype wire

// file: verif/cssc_top_props.sv
`timescale 1ns/1ps
`default_nettype none

// watches the clock control ports of cssc_top
module cssc_top_chk (
  // clock and reset
  input wire logic       clk,
  input wire logic       rst,
  // fuse image and pins
  input wire logic [3:0] source_select_fuses,
  input wire logic       divide_by_eight_fuse,
  input wire logic [7:0] calib_byte,
  input wire logic       wd_osc_pin,
  input wire logic       ext_irq_pin,
  input wire logic       serial_start_pin,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  // clock control outputs
  input wire logic       core_run,
  input wire logic       cpu_clk_en,
  input wire logic       flash_clk_en,
  input wire logic [2:0] src_class,
  input wire logic [2:0] xtal_mode,
  input wire logic [6:0] trim_value,
  input wire logic [3:0] prescaler_select,
  input wire logic       wd_clk_for_watchdog,
  input wire logic       async_wake
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // helper slices and the expected source class
  wire [6:0] calib_low = calib_byte[6:0];
  wire [6:0] wdata_low = reg_wdata[6:0];
  wire [2:0] src_hi    = source_select_fuses[3:1];
  wire [2:0] cls_exp   = source_select_fuses[3] ? 3'h4 : {1'b0, source_select_fuses[2:1]};

  // first edge after reset release
  sequence start_s;
    $fell(rst);
  endsequence

  calib_load_a: assert property (start_s |=> trim_value == $past(calib_low))
    else $error("trim not loaded from calibration byte");
  presc_init_a: assert property (start_s |=> prescaler_select == ($past(divide_by_eight_fuse) ? 4'h0 : 4'h3))
    else $error("prescaler reset value wrong");
  src_decode_a: assert property (start_s |=> src_class == $past(cls_exp))
    else $error("source class decode wrong");
  xtal_mode_a: assert property (start_s |=> xtal_mode == $past(src_hi))
    else $error("crystal mode decode wrong");
  core_hold_a: assert property (start_s |-> !core_run [*8])
    else $error("core released too early");
  flash_clk_a: assert property (flash_clk_en == cpu_clk_en)
    else $error("flash clock not with cpu clock");
  clk_gate_a: assert property (!core_run |-> !cpu_clk_en)
    else $error("cpu clock runs while core held");
  async_wake_a: assert property (async_wake == (ext_irq_pin | serial_start_pin))
    else $error("async wake not from pins");
  wd_route_a: assert property (wd_clk_for_watchdog == wd_osc_pin)
    else $error("watchdog clock not routed");
  trim_read_a: assert property (reg_rd && reg_addr == 4'h0 |=> reg_rdata[6:0] == $past(trim_value))
    else $error("trim read value wrong");
  trim_write_a: assert property (reg_wr && reg_addr == 4'h0 && !$past(rst) |=> trim_value == $past(wdata_low))
    else $error("trim write lost");
endmodule // cssc_top_chk

bind cssc_top cssc_top_chk u_cssc_top_chk (
  .clk(clk), .rst(rst), .source_select_fuses(source_select_fuses),
  .divide_by_eight_fuse(divide_by_eight_fuse), .calib_byte(calib_byte), .wd_osc_pin(wd_osc_pin),
  .ext_irq_pin(ext_irq_pin), .serial_start_pin(serial_start_pin), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .core_run(core_run), .cpu_clk_en(cpu_clk_en), .flash_clk_en(flash_clk_en),
  .src_class(src_class), .xtal_mode(xtal_mode), .trim_value(trim_value),
  .prescaler_select(prescaler_select), .wd_clk_for_watchdog(wd_clk_for_watchdog),
  .async_wake(async_wake));

`default_nettype wire

// file: verif/cssc_top_tb.sv
`timescale 1ns/1ps
`default_nettype none

module cssc_top_tb;
  // stimulus
  reg        clk = 1'b0, rst = 1'b1, div_f = 1'b0, wd = 1'b0, wake = 1'b0, pd = 1'b0;
  reg        irq = 1'b0, sst = 1'b0, wr_s = 1'b0, rd_s = 1'b0, ok;
  reg  [3:0] src_f = 4'h0, addr = 4'h0;
  reg  [1:0] sut_f = 2'h0;
  reg  [7:0] calib = 8'h00, wdata = 8'h00, lf = 8'h5e, d, c;
  // observed outputs
  wire [7:0] rdata;
  wire       run, cpu_en, fl_en, wdo, aw;
  wire [2:0] cls, xm;
  wire [6:0] trim;
  wire [3:0] presc;
  integer    miscompares = 0, total_checks = 0, i, n, a, e, w;

  cssc_top u_cssc_top (
    .clk(clk), .rst(rst), .source_select_fuses(src_f), .startup_select_fuses(sut_f),
    .divide_by_eight_fuse(div_f), .calib_byte(calib), .wd_osc_pin(wd), .wake_req(wake),
    .power_down(pd), .ext_irq_pin(irq), .serial_start_pin(sst), .reg_addr(addr),
    .reg_wdata(wdata), .reg_wr(wr_s), .reg_rd(rd_s), .reg_rdata(rdata), .core_run(run),
    .cpu_clk_en(cpu_en), .flash_clk_en(fl_en), .src_class(cls), .xtal_mode(xm),
    .trim_value(trim), .prescaler_select(presc), .wd_clk_for_watchdog(wdo), .async_wake(aw));

  // 20 MHz clock, watchdog oscillator at half rate
  always #25 clk = ~clk;
  always @(posedge clk) wd <= ~wd;

  // random source
  function [7:0] nx(input [7:0] v);
    nx = {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction

  // reset delay model: 0 none, 1 4K, 2 64K watchdog cycles
  function integer rdel(input [3:0] s, input [1:0] u);
    reg [2:0] k;
    begin
      k = {s[0], u};
      if (s[3]) rdel = (k % 3 == 2) ? 0 : (k % 3 == 0) ? 1 : 2;
      else rdel = (u == 2'h0) ? 0 : (u == 2'h1) ? 1 : 2;
    end
  endfunction

  // wake-up count model
  function integer wk(input [3:0] s, input [1:0] u);
    reg [2:0] k;
    begin
      k = {s[0], u};
      wk = !s[3] ? 6 : (k < 2) ? 258 : (k < 5) ? 1024 : 16384;
    end
  endfunction

  task chk(input [31:0] seen, input [31:0] exp);
    begin
      total_checks = total_checks + 1;
      if (seen !== exp) begin
        miscompares = miscompares + 1;
        $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask

  task wrt(input [3:0] ad, input [7:0] dt);
    begin
      @(posedge clk);
      addr <= ad;
      wdata <= dt;
      wr_s <= 1'b1;
      @(posedge clk);
      wr_s <= 1'b0;
    end
  endtask

  task rdr(input [3:0] ad);
    begin
      @(posedge clk);
      addr <= ad;
      rd_s <= 1'b1;
      @(posedge clk);
      rd_s <= 1'b0;
      #1 d = rdata;
    end
  endtask

  // count cycles until the core is released, bounded
  task wait_run(input integer lim);
    begin
      n = 0;
      while (run !== 1'b1 && n < lim) begin
        @(posedge clk);
        #1 n = n + 1;
      end
    end
  endtask

  // reset with a fuse image, check decode, then release or, for a 64K delay, a 400-cycle hold, and wake unless the delay is 64K or the wake figure 16K
  task start(input [3:0] s, input [1:0] u, input v);
    begin
      @(posedge clk);
      rst <= 1'b1;
      src_f <= s;
      sut_f <= u;
      div_f <= v;
      c = lf;
      calib <= lf;
      irq <= lf[0];
      sst <= lf[1];
      repeat (8) @(posedge clk);
      #1 chk(presc, 4'h3);
      chk(cls, 3'h1);
      chk(xm, 3'h1);
      chk(run, 0);
      @(posedge clk);
      rst <= 1'b0;
      e = rdel(s, u);
      w = wk(s, u);
      wait_run(e == 2 ? 400 : 8300);
      ok = e == 0 ? (n >= 14 && n <= 20) : e == 1 ? (n >= 8200 && n <= 8240) : (n == 400);
      chk(ok, 1);
      chk(cls, s[3] ? 3'h4 : {1'b0, s[2:1]});
      chk(xm, s[3:1]);
      chk(presc, v ? 4'h0 : 4'h3);
      chk(trim, c[6:0]);
      chk(aw, irq | sst);
      chk(fl_en, e != 2);
      chk(wdo, wd);
      rdr(4'h2);
      chk(d, {1'b0, v, u, s});
      rdr(4'h0);
      chk(d, c);
      if (e != 2 && w < 2000) begin
        chk(cpu_en, 1);
        @(posedge clk);
        wake <= 1'b1;
        repeat (4) @(posedge clk);
        wake <= 1'b0;
        #1 chk(run, 1);
        @(posedge clk);
        pd <= 1'b1;
        repeat (4) @(posedge clk);
        #1 chk(cpu_en, 0);
        chk(fl_en, 0);
        @(posedge clk);
        wake <= 1'b1;
        n = 0;
        while (run === 1'b1 && n < 12) begin
          @(posedge clk);
          #1 n = n + 1;
        end
        chk(n < 12, 1);
        @(posedge clk);
        pd <= 1'b0;
        wake <= 1'b0;
        wait_run(17000);
        chk(n >= w - 3 && n <= w + 4, 1);
      end
    end
  endtask

  task complete_run;
    begin
      $display("checks %0d miscompares %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask

  // factory image, registers, then every source code
  initial begin
    start(4'h2, 2'h2, 1'b0);
    lf = nx(lf);
    // trim step kept below 0x20, no nonvolatile write in flight
    c = c + {3'h0, lf[4:0]};
    wrt(4'h0, c);
    rdr(4'h0);
    chk(d, c);
    chk(trim, c[6:0]);
    rdr(4'h1);
    n = d;
    wrt(4'h1, ~d);
    rdr(4'h1);
    chk(d, n);
    wrt(4'h3, lf);
    rdr(4'h3);
    chk(d[3:0], lf[3:0]);
    for (a = 4; a < 16; a = a + 1) begin
      wrt(a[3:0], 8'hff);
      rdr(a[3:0]);
      chk(d, 0);
    end
    chk(trim, c[6:0]);
    for (i = 0; i < 16; i = i + 1) begin
      lf = nx(lf);
      // the 8 MHz rc source always starts divided by eight
      start(i[3:0], i[3] ? i[2:1] : lf[1:0], lf[2] & (i[3:1] != 3'h2));
    end
    complete_run;
  end

  // hang guard
  initial begin
    // about 50k cycles expected; give up at 80k
    #4000000;
    miscompares = miscompares + 1;
    complete_run;
  end
endmodule // cssc_top_tb

`default_nettype wire
